// >>> hw/imrtr_pkg.sv
// Constants, register map and state type of the I2C master sequencer.
package imrtr_pkg;
  localparam int CLK_NS       = 10;
  localparam int TCY_NS       = 40;
  localparam int TICK_CYC     = TCY_NS / (2 * CLK_NS);
  localparam int WRITE_COLLISION_FLAG_WIN_NS  = 2 * TCY_NS;
  localparam int WRITE_COLLISION_FLAG_WIN_CYC = WRITE_COLLISION_FLAG_WIN_NS / CLK_NS;
  localparam int ADDR_W       = 8;
  localparam logic [7:0] OFS_CTRL2  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RELOAD = 8'h08;
  localparam logic [7:0] OFS_BUF    = 8'h0C;
  localparam logic [7:0] OFS_FLAGS  = 8'h10;
  localparam logic [2:0] SEL_CTRL2  = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_RELOAD = 3'h2;
  localparam logic [2:0] SEL_BUF    = 3'h3;
  localparam logic [2:0] SEL_FLAGS  = 3'h4;
  localparam logic [2:0] SEL_NONE   = 3'h7;
  localparam int CTL_REPEATED_START_ENABLE    = 1;
  localparam int CTL_RECEIVE_ENABLE_BIT    = 3;
  localparam int CTL_ACK_VALUE_BIT   = 5;
  localparam int CTL_ACK_RECEIVED_STATUS = 6;
  localparam int ST_BF       = 0;
  localparam int ST_START    = 3;
  localparam int FL_EVT      = 0;
  localparam int FL_WRITE_COLLISION_FLAG     = 1;
  localparam int FL_OVF      = 2;
  localparam int FL_BCL      = 3;
  localparam logic [6:0] RELOAD_RST = 7'h13;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_RS1 = 4'h1, S_RS2 = 4'h3, S_RS3 = 4'h2, S_RS4 = 4'h6,
    S_TXL  = 4'h7, S_TXH = 4'h5, S_RXL = 4'hC, S_RXH = 4'hD
  } imrtr_state_t;
endpackage : imrtr_pkg

// >>> hw/imrtr_top.sv
// I2C master repeated start, byte transmit and byte receive with AXI4-Lite registers.
// Operation
// - Repeated start begins only when its enable is written while idle.
// - Pull SCL low; once low, load counter from six bits, release SDA.
// - On expiry with SDA high release SCL; when high reload seven bits.
// - After one high period drive SDA low one period, then clear enable.
// - Start-detected bit follows bus lines; event flag waits for counter expiry.
// - Repeated start enable written during another event is ignored.
// - Collision: SDA low as SCL rises, or SCL falls before SDA pulled.
// - Buffer write during repeated start or reception sets collision, no update.
// - Low five control bits ignore writes until repeated start completes.
// - Buffer write sets buffer-full and starts the counter for a byte.
// - SDA changes after SCL falls; low one period, high one period; MSB first.
// - Eighth falling edge clears buffer-full and releases SDA for acknowledge.
// - Ninth falling edge samples SDA into acknowledge status.
// - After ninth clock set event flag, stop counter, hold SCL low.
// - Write during transmit sets collision; updates buffer only within two cycles.
// - Buffer-full set by write, cleared when eight bits shifted out.
// - Receive enable starts reception only when idle.
// - Receive toggles SCL each expiry and shifts SDA in each clock.
// - After eighth received clock: clear enable, load buffer, set flags, hold SCL.
// - Reading the buffer in receive operation clears buffer-full.
// - Byte arriving while buffer-full is set raises overflow.
// - Counter reloads seven bits, decrements twice per instruction cycle, stops at zero.
// - After SCL release the counter waits until SCL is sampled high.
`timescale 1ns/1ps
module imrtr_top
  import imrtr_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic              SCL_I,
  output logic                   SCL_O,
  output logic                   SCL_OE_B,
  input  wire logic              SDA_I,
  output logic                   SDA_O,
  output logic                   SDA_OE_B
);
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL2:  reg_sel = SEL_CTRL2;
      OFS_STATUS: reg_sel = SEL_STATUS;
      OFS_RELOAD: reg_sel = SEL_RELOAD;
      OFS_BUF:    reg_sel = SEL_BUF;
      OFS_FLAGS:  reg_sel = SEL_FLAGS;
      default:    reg_sel = SEL_NONE;
    endcase
  endfunction : reg_sel

  imrtr_state_t      state_r, state_nxt;
  logic [2:0]        scl_s_r, sda_s_r;
  logic              scl_f, sda_f, scl_q_r, sda_q_r;
  logic [3:0]        tdiv_r;
  logic              tick_r;
  logic [6:0]        cnt_r, reload_r;
  logic [3:0]        bitc_r, wwin_r;
  logic [7:0]        shf_r, buf_r;
  logic              bf_r, repeated_start_enable_r, receive_enable_bit_r, ack_value_bit_r, ack_received_status_r, rxm_r;
  logic              evt_r, write_collision_flag_r, ovf_r, bcl_r, sdet_r;
  logic              scl_oe_b_r, sda_oe_b_r, scl_nxt, sda_nxt;
  logic              ld_w, ld6_w, step_w, rs_done_w, bcl_w;
  logic              aw_got_r, w_got_r;
  logic [ADDR_W-1:0] wa_r;
  logic [7:0]        wd_r;
  logic              wstb_r;

  // Bus-side decode.
  wire             wr_do_w    = aw_got_r && w_got_r && !S_AXI_BVALID;
  wire       [2:0] wsel_w     = reg_sel(wa_r);
  wire       [2:0] rsel_w     = reg_sel(S_AXI_ARADDR);
  wire             wr_en_w    = wr_do_w && wstb_r;
  wire             ctl_wr_w   = wr_en_w && wsel_w == SEL_CTRL2;
  wire             buf_wr_w   = wr_en_w && wsel_w == SEL_BUF;
  wire             flg_wr_w   = wr_en_w && wsel_w == SEL_FLAGS;
  wire             ar_hs_w    = S_AXI_ARVALID && S_AXI_ARREADY;
  wire             rd_buf_w   = ar_hs_w && rsel_w == SEL_BUF && rxm_r;
  wire             idle_w     = state_r == S_IDLE;
  wire             tx_w       = state_r == S_TXL || state_r == S_TXH;
  wire             ctl_ok_w   = ctl_wr_w && !repeated_start_enable_r;
  wire             rs_go_w    = ctl_ok_w && wd_r[CTL_REPEATED_START_ENABLE] && idle_w;
  wire             rx_go_w    = ctl_ok_w && wd_r[CTL_RECEIVE_ENABLE_BIT] && !wd_r[CTL_REPEATED_START_ENABLE]
                                && idle_w;
  wire             tx_go_w    = buf_wr_w && idle_w && !rs_go_w;
  wire             hi_w       = state_r == S_RS3 || state_r == S_RS4 || state_r == S_TXH
                                || state_r == S_RXH;
  wire             cnt_on_w   = !idle_w && state_r != S_RS1 && (!hi_w || scl_f);
  wire             tmo_w      = cnt_on_w && cnt_r == 7'h00;
  wire       [6:0] ldv_w      = ld6_w ? {1'b0, reload_r[5:0]} : reload_r;
  wire             tx_step_w  = step_w && state_r == S_TXH;
  wire             rx_step_w  = step_w && state_r == S_RXH;
  wire             tx_done_w  = tx_step_w && bitc_r == 4'h8;
  wire             rx_done_w  = rx_step_w && bitc_r == 4'h7;
  wire       [7:0] rx_shf_w   = {shf_r[6:0], sda_f};
  wire             scl_fall_w = scl_q_r && !scl_f;
  wire             scl_rise_w = !scl_q_r && scl_f;
  wire       [7:0] rd_ctl_w   = {1'b0, ack_received_status_r, ack_value_bit_r, 1'b0, receive_enable_bit_r, 1'b0, repeated_start_enable_r, 1'b0};
  wire       [7:0] rd_st_w    = {4'h0, sdet_r, 2'h0, bf_r};
  wire       [7:0] rd_fl_w    = {4'h0, bcl_r, ovf_r, write_collision_flag_r, evt_r};
  wire       [7:0] rd_mux_w   = rsel_w == SEL_CTRL2  ? rd_ctl_w :
                                rsel_w == SEL_STATUS ? rd_st_w :
                                rsel_w == SEL_RELOAD ? {1'b0, reload_r} :
                                rsel_w == SEL_BUF    ? buf_r : rd_fl_w;

  // Pin inputs: three stages, filtered level moves once stages two and three agree.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f   <= 1'b1;
      sda_f   <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], SCL_I};
      sda_s_r <= {sda_s_r[1:0], SDA_I};
      if (scl_s_r[1] == scl_s_r[2]) scl_f <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f <= sda_s_r[2];
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // Two counter steps per instruction cycle.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      tdiv_r <= 4'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= tdiv_r == 4'(TICK_CYC - 1);
      tdiv_r <= (tdiv_r == 4'(TICK_CYC - 1)) ? 4'h0 : tdiv_r + 4'h1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) cnt_r <= 7'h00;
    else if (ld_w) cnt_r <= ldv_w;
    else if (tick_r && cnt_on_w && cnt_r != 7'h00) cnt_r <= cnt_r - 7'h01;
  end

  always_comb begin
    state_nxt = state_r;
    scl_nxt   = scl_oe_b_r;
    sda_nxt   = sda_oe_b_r;
    ld_w      = 1'b0;
    ld6_w     = 1'b0;
    step_w    = 1'b0;
    rs_done_w = 1'b0;
    bcl_w     = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (rs_go_w) begin
          state_nxt = S_RS1;
          scl_nxt   = 1'b0;
        end else if (rx_go_w) begin
          state_nxt = S_RXL;
          scl_nxt   = 1'b0;
          sda_nxt   = 1'b1;
          ld_w      = 1'b1;
        end else if (tx_go_w) begin
          state_nxt = S_TXL;
          scl_nxt   = 1'b0;
          ld_w      = 1'b1;
        end
      end
      S_RS1: begin
        if (!scl_f) begin
          state_nxt = S_RS2;
          ld_w      = 1'b1;
          ld6_w     = 1'b1;
          sda_nxt   = 1'b1;
        end
      end
      S_RS2: begin
        if (tmo_w && sda_f) begin
          state_nxt = S_RS3;
          scl_nxt   = 1'b1;
          ld_w      = 1'b1;
        end else if (tmo_w) begin
          bcl_w = 1'b1;
        end
      end
      S_RS3: begin
        ld_w = !scl_f;
        if ((scl_rise_w && !sda_f) || scl_fall_w) begin
          bcl_w = 1'b1;
        end else if (tmo_w) begin
          state_nxt = S_RS4;
          sda_nxt   = 1'b0;
          ld_w      = 1'b1;
        end
      end
      S_RS4: begin
        ld_w = !scl_f;
        if (tmo_w) begin
          state_nxt = S_IDLE;
          rs_done_w = 1'b1;
        end
      end
      S_TXL: begin
        if (!scl_f) sda_nxt = bitc_r == 4'h8 || shf_r[7];
        if (tmo_w) begin
          state_nxt = S_TXH;
          scl_nxt   = 1'b1;
          ld_w      = 1'b1;
        end
      end
      S_TXH: begin
        ld_w = !scl_f;
        if (tmo_w) begin
          step_w    = 1'b1;
          scl_nxt   = 1'b0;
          ld_w      = 1'b1;
          state_nxt = bitc_r == 4'h8 ? S_IDLE : S_TXL;
        end
      end
      S_RXL: begin
        if (tmo_w) begin
          state_nxt = S_RXH;
          scl_nxt   = 1'b1;
          ld_w      = 1'b1;
        end
      end
      S_RXH: begin
        ld_w = !scl_f;
        if (tmo_w) begin
          step_w    = 1'b1;
          scl_nxt   = 1'b0;
          ld_w      = 1'b1;
          state_nxt = bitc_r == 4'h7 ? S_IDLE : S_RXL;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    if (bcl_w) begin
      state_nxt = S_IDLE;
      scl_nxt   = 1'b1;
      sda_nxt   = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_r    <= S_IDLE;
      scl_oe_b_r <= 1'b1;
      sda_oe_b_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      scl_oe_b_r <= scl_nxt;
      sda_oe_b_r <= sda_nxt;
    end
  end

  // Shift path and bit counter.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      bitc_r <= 4'h0;
      shf_r  <= 8'h00;
    end else if (tx_go_w || rx_go_w) begin
      bitc_r <= 4'h0;
      shf_r  <= tx_go_w ? wd_r : 8'h00;
    end else if (step_w) begin
      bitc_r <= bitc_r + 4'h1;
      shf_r  <= rx_step_w ? rx_shf_w : {shf_r[6:0], 1'b0};
    end
  end

  // Transfer buffer, collision window and buffer-full.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      buf_r  <= 8'h00;
      wwin_r <= 4'h0;
      rxm_r  <= 1'b0;
      bf_r   <= 1'b0;
    end else begin
      if (tx_go_w || (buf_wr_w && tx_w && wwin_r != 4'h0)) buf_r <= wd_r;
      else if (rx_done_w) buf_r <= rx_shf_w;
      if (tx_go_w) wwin_r <= 4'(WRITE_COLLISION_FLAG_WIN_CYC);
      else if (wwin_r != 4'h0) wwin_r <= wwin_r - 4'h1;
      if (tx_go_w) rxm_r <= 1'b0;
      else if (rx_go_w) rxm_r <= 1'b1;
      bf_r <= tx_go_w || rx_done_w || (bf_r && !rd_buf_w
              && !(tx_step_w && bitc_r == 4'h7));
    end
  end

  // Control and status bits; hardware sets win over software clears.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      repeated_start_enable_r    <= 1'b0;
      receive_enable_bit_r    <= 1'b0;
      ack_value_bit_r   <= 1'b0;
      ack_received_status_r <= 1'b0;
      reload_r  <= RELOAD_RST;
      sdet_r    <= 1'b0;
    end else begin
      repeated_start_enable_r <= rs_go_w || (repeated_start_enable_r && !rs_done_w && !bcl_w);
      receive_enable_bit_r <= rx_go_w || (receive_enable_bit_r && !rx_done_w);
      if (ctl_wr_w) ack_value_bit_r <= wd_r[CTL_ACK_VALUE_BIT];
      if (tx_done_w) ack_received_status_r <= sda_f;
      if (wr_en_w && wsel_w == SEL_RELOAD) reload_r <= wd_r[6:0];
      if (scl_f && sda_q_r && !sda_f) sdet_r <= 1'b1;
      else if (scl_f && !sda_q_r && sda_f) sdet_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      evt_r  <= 1'b0;
      write_collision_flag_r <= 1'b0;
      ovf_r  <= 1'b0;
      bcl_r  <= 1'b0;
    end else begin
      evt_r  <= rs_done_w || tx_done_w || rx_done_w
                || (evt_r && !(flg_wr_w && wd_r[FL_EVT]));
      write_collision_flag_r <= (buf_wr_w && !idle_w)
                || (write_collision_flag_r && !(flg_wr_w && wd_r[FL_WRITE_COLLISION_FLAG]));
      ovf_r  <= (rx_done_w && bf_r && !rd_buf_w)
                || (ovf_r && !(flg_wr_w && wd_r[FL_OVF]));
      bcl_r  <= bcl_w || (bcl_r && !(flg_wr_w && wd_r[FL_BCL]));
    end
  end

  // AXI4-Lite write channel: address and data taken in either order.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      wa_r          <= '0;
      wd_r          <= 8'h00;
      wstb_r        <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r      <= 1'b1;
        wa_r          <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r      <= 1'b1;
        wd_r         <= S_AXI_WDATA[7:0];
        wstb_r       <= S_AXI_WSTRB[0];
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_do_w) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wsel_w == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (ar_hs_w) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rsel_w == SEL_NONE ? 32'h0000_0000 : {24'h00_0000, rd_mux_w};
      S_AXI_RRESP   <= rsel_w == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // Open-drain pins: the data outputs are a constant low flop.
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      SCL_O    <= 1'b0;
      SDA_O    <= 1'b0;
      SCL_OE_B <= 1'b1;
      SDA_OE_B <= 1'b1;
    end else begin
      SCL_O    <= 1'b0;
      SDA_O    <= 1'b0;
      SCL_OE_B <= scl_nxt;
      SDA_OE_B <= sda_nxt;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  property p_rs_go;
    rs_go_w |=> state_r == S_RS1 && !SCL_OE_B;
  endproperty
  a_rs_go: assert property (p_rs_go) else $error("Repeated start did not pull SCL low.");
  property p_rs_load;
    (state_r == S_RS1 && !scl_f) |=> cnt_r <= 7'h3F && SDA_OE_B;
  endproperty
  a_rs_load: assert property (p_rs_load) else $error("Six-bit load or SDA release wrong.");
  property p_rs_end;
    (state_r == S_RS4 && tmo_w) |=> !repeated_start_enable_r && evt_r && !SDA_OE_B && idle_w;
  endproperty
  a_rs_end: assert property (p_rs_end) else $error("Repeated start end wrong.");
  property p_rs_busy;
    (ctl_wr_w && wd_r[CTL_REPEATED_START_ENABLE] && !idle_w) |=> state_r != S_RS1;
  endproperty
  a_rs_busy: assert property (p_rs_busy) else $error("Busy repeated start accepted.");
  property p_bcl;
    (state_r == S_RS3 && scl_rise_w && !sda_f) |=> bcl_r && idle_w && SCL_OE_B;
  endproperty
  a_bcl: assert property (p_bcl) else $error("Collision not reported.");
  property p_write_collision_flag;
    (buf_wr_w && !idle_w && !tx_w) |=> write_collision_flag_r && $stable(buf_r);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("Busy buffer write not refused.");
  property p_tx_go;
    tx_go_w |=> bf_r && state_r == S_TXL && !SCL_OE_B;
  endproperty
  a_tx_go: assert property (p_tx_go) else $error("Buffer write did not start byte.");
  property p_bf_clr;
    (tx_step_w && bitc_r == 4'h7) |=> !bf_r ##[1:8] SDA_OE_B;
  endproperty
  a_bf_clr: assert property (p_bf_clr) else $error("Eighth edge handling wrong.");
  property p_ack;
    tx_done_w |=> ack_received_status_r == $past(sda_f) && evt_r && idle_w && !SCL_OE_B;
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge sample wrong.");
  property p_rx_done;
    rx_done_w |=> !receive_enable_bit_r && bf_r && evt_r && buf_r[0] == $past(sda_f) && !SCL_OE_B;
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("Receive completion wrong.");
  property p_ovf;
    (rx_done_w && bf_r && !rd_buf_w) |=> ovf_r;
  endproperty
  a_ovf: assert property (p_ovf) else $error("Overflow not flagged.");
  property p_cnt;
    (tick_r && cnt_on_w && cnt_r != 7'h00 && !ld_w) |=> cnt_r == $past(cnt_r) - 7'h01;
  endproperty
  a_cnt: assert property (p_cnt) else $error("Counter step wrong.");
  property p_stretch;
    (hi_w && !scl_f && !bcl_w) |=> cnt_r == $past(ldv_w);
  endproperty
  a_stretch: assert property (p_stretch) else $error("Counter ran while SCL low.");
  c_rs: cover property (rs_done_w);
  c_tx: cover property (tx_done_w);
  c_rx: cover property (rx_done_w);
  c_bcl: cover property (bcl_w);
endmodule : imrtr_top

// >>> sim/imrtr_slave.sv
// Behavioural I2C slave that answers byte transfers of the master.
`timescale 1ns/1ps
module imrtr_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       arm,
  input  wire logic       rd_mode,
  input  wire logic       ack_n,
  input  wire logic [7:0] tx_byte,
  input  wire logic [7:0] stretch_ns,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      rx_byte
);
  int   rises = 9;
  int   idx = 9;
  logic ack_on = 1'b0;
  initial scl_pull = 1'b0;
  initial rx_byte = 8'h00;
  always @(posedge arm) begin
    rises = 0;
    idx = 0;
  end
  always @(posedge scl) begin
    if (rises < 8) rx_byte = {rx_byte[6:0], sda};
    rises = rises + 1;
  end
  // Data changes only after a falling edge; a stretch holds the clock low meanwhile.
  always @(negedge scl) begin
    idx = rises;
    ack_on = (rises == 8) && !rd_mode && !ack_n;
    if (stretch_ns != 8'h00) begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end
  end
  assign sda_pull = ack_on || (rd_mode && idx < 8 && !tx_byte[7 - idx]);
endmodule : imrtr_slave

// >>> sim/tb_imrtr_top.sv
// Self-checking bench of the I2C master sequencer against a slave model.
`timescale 1ns/1ps
module tb_imrtr_top;
  import imrtr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_byte = 8'h00, stretch = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic        awready, wready, bvalid, arready, rvalid, scl_oe_b, sda_oe_b;
  logic [1:0]  bresp, rresp, rr;
  logic        arm = 1'b0, rd_mode = 1'b0, ack_n = 1'b0, scl_pull, sda_pull;
  logic        scl_o, sda_o;
  logic [7:0]  rx_byte, b;
  wire         scl = scl_oe_b & ~scl_pull;
  wire         sda = sda_oe_b & ~sda_pull;
  int          error_cnt = 0, n_checks = 0, seed = 63, rnd;
  logic [7:0]  q_exp[$];
  always #5 clk = ~clk;
  imrtr_top dut (
    .CLK(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_B(scl_oe_b), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_B(sda_oe_b));
  imrtr_slave slave (.scl(scl), .sda(sda), .arm(arm), .rd_mode(rd_mode), .ack_n(ack_n),
    .tx_byte(tx_byte), .stretch_ns(stretch), .scl_pull(scl_pull), .sda_pull(sda_pull),
    .rx_byte(rx_byte));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrm(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, (a <= OFS_FLAGS) ? RESP_OKAY : RESP_SLVERR});
  endtask : wrm
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
    if (m != 32'h0) chk(rv & m, e);
    if (m != 32'h0) chk({30'h0, rr}, {30'h0, (a <= OFS_FLAGS) ? RESP_OKAY : RESP_SLVERR});
  endtask : rdm
  // Polls until the event flag is seen; only the watchdog ends a hang here.
  task automatic wait_evt;
    do begin
      rdm(OFS_FLAGS, 32'h0, 32'h0);
    end while (rv[FL_EVT] !== 1'b1);
  endtask : wait_evt
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    #300000;
    error_cnt++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rdm(OFS_STATUS, 32'hFF, 32'h0);
    rdm(OFS_RELOAD, 32'hFFFF_FFFF, {25'h0, RELOAD_RST});
    rdm(8'h14, 32'hFFFF_FFFF, 32'h0);
    wrm(8'h14, 32'hFF);
    wrm(OFS_RELOAD, 32'h3);
    rdm(OFS_RELOAD, 32'hFF, 32'h3);
    wrm(OFS_CTRL2, 32'h20);
    rdm(OFS_CTRL2, 32'h2A, 32'h20);
    $display("register test done");
    wrm(OFS_CTRL2, 32'h02);
    wrm(OFS_BUF, 32'hA5);
    wrm(OFS_CTRL2, 32'h28);
    wait_evt;
    chk({26'h0, scl_o, sda_o, scl_oe_b, sda_oe_b, scl, sda}, 32'hA);
    // Bit 5 lies above the five locked bits, so the busy write still lands there.
    rdm(OFS_CTRL2, 32'h2A, 32'h20);
    rdm(OFS_STATUS, 32'h09, 32'h08);
    rdm(OFS_FLAGS, 32'h0F, 32'h03);
    wrm(OFS_FLAGS, 32'hF);
    $display("repeated start test done");
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      b = rnd[7:0];
      ack_n <= rnd[8];
      stretch <= i[0] ? 8'hC8 : 8'h00;
      arm <= 1'b1;
      q_exp.push_back(b);
      wrm(OFS_BUF, {24'h0, b});
      arm <= 1'b0;
      if (i == 0) wrm(OFS_BUF, {24'h0, ~b});
      rdm(OFS_STATUS, 32'h1, 32'h1);
      if (i == 1) begin
        // Let the two-cycle update window lapse so that this write is discarded.
        repeat (8) @(posedge clk);
        wrm(OFS_BUF, {24'h0, ~b});
      end
      wait_evt;
      chk({24'h0, rx_byte}, {24'h0, q_exp.pop_front()});
      chk({30'h0, scl_oe_b, scl}, 32'h0);
      rdm(OFS_CTRL2, 32'h40, {25'h0, ack_n, 6'h0});
      rdm(OFS_STATUS, 32'h1, 32'h0);
      rdm(OFS_FLAGS, 32'hF, (i < 2) ? 32'h3 : 32'h1);
      rdm(OFS_BUF, 32'hFF, {24'h0, (i == 0) ? ~b : b});
      wrm(OFS_FLAGS, 32'hF);
    end
    $display("transmit test done");
    for (int i = 0; i < 2; i++) begin
      rnd = $random(seed);
      tx_byte <= rnd[7:0];
      q_exp.push_back(rnd[7:0]);
      rd_mode <= 1'b1;
      stretch <= i[0] ? 8'hC8 : 8'h00;
      arm <= 1'b1;
      wrm(OFS_CTRL2, 32'h08);
      arm <= 1'b0;
      wrm(OFS_BUF, 32'h3C);
      if (i == 1) wrm(OFS_CTRL2, 32'h0A);
      wait_evt;
      rdm(OFS_FLAGS, 32'hF, (i == 1) ? 32'h7 : 32'h3);
      rdm(OFS_CTRL2, 32'h0A, 32'h0);
      rdm(OFS_STATUS, 32'h1, 32'h1);
      chk({31'h0, scl_oe_b}, 32'h0);
      wrm(OFS_FLAGS, 32'hF);
    end
    void'(q_exp.pop_front());
    rdm(OFS_BUF, 32'hFF, {24'h0, q_exp.pop_front()});
    rdm(OFS_STATUS, 32'h1, 32'h0);
    $display("receive test done");
    conclude;
  end
endmodule : tb_imrtr_top
